// *** design/rsp_reset_mgr.sv ***
/*
  rsp_reset_mgr: reset state manager. Arbitrates general, backup,
  watchdog, software and user reset sources by fixed priority and
  holds internal resets low while the external reset pin is low.
  Assumes all requests are synchronous to clk_sys (the slow clock),
  and the pin wire is resolved outside from pin output and enable.
*/
`timescale 1ns/1ps
// How it works
// - pin held low at least programmed length
// - internal resets held while pin low outside
// - priority general, backup, watchdog, software, user
// - no watchdog event during user reset
// - no software reset during user reset
// - watchdog preempts a software reset
// - pin activity ignored during software reset
// - processor reset stays active in watchdog reset
// - user reset never entered from watchdog
module rsp_reset_mgr
	import rsp_pkg::*;
#(
	parameter int LEN_W = RSP_LEN_W
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// reset sources
	input wire logic gen_rst_req,
	input wire logic bkp_rst_req,
	input wire logic wdt_event,
	input wire logic sw_rst_req,
	// configuration
	input wire logic [LEN_W-1:0] ext_reset_length,
	// external reset pin, open drain
	input wire logic ext_reset_pin_n_lvl,
	output logic ext_reset_pin_n_val,
	output logic ext_reset_pin_n_oe,
	// internal resets and status
	output logic proc_rst_b,
	output logic periph_rst_b,
	output rsp_state_t rst_state,
	output rsp_state_t rst_cause
);
	rsp_state_t state_ff;
	rsp_state_t nxt_state;
	rsp_state_t cause_ff;
	rsp_state_t nxt_cause;
	logic proc_rst_b_ff;
	logic nxt_proc_rst_b;
	logic periph_rst_b_ff;
	logic nxt_periph_rst_b;
	logic start;
	logic pin_low_ext;

	rsp_pin_if pif ();

	rsp_pin_drv u_pin_drv (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pin_lvl(ext_reset_pin_n_lvl),
		.pif(pif),
		.pin_val(ext_reset_pin_n_val),
		.pin_oe(ext_reset_pin_n_oe)
	);

	// a low level we are not making ourselves is a user request
	assign pin_low_ext = (ext_reset_pin_n_lvl == RSP_PIN_LOW) && !pif.driving;

	// a user reset follows the pin, every other reset drives it
	function automatic logic drives_pin(input rsp_state_t s);
		drives_pin = (s != RSP_ST_IDLE) && (s != RSP_ST_USER);
	endfunction

	always_comb begin
		nxt_state = state_ff;
		nxt_cause = cause_ff;
		start = 1'b0;
		if (gen_rst_req) begin
			nxt_state = RSP_ST_GEN;
		end else if (bkp_rst_req && state_ff != RSP_ST_GEN) begin
			nxt_state = RSP_ST_BKP;
		end else if (wdt_event && (state_ff == RSP_ST_IDLE || state_ff == RSP_ST_SW)) begin
			// watchdog is itself held in reset during a user reset
			nxt_state = RSP_ST_WDT;
		end else if (sw_rst_req && state_ff == RSP_ST_IDLE) begin
			// processor is held in reset in watchdog and user states
			nxt_state = RSP_ST_SW;
		end else if (pin_low_ext && state_ff == RSP_ST_IDLE) begin
			// a low pin starts no user reset in software or watchdog states
			nxt_state = RSP_ST_USER;
		end else if (state_ff != RSP_ST_IDLE && pif.done) begin
			nxt_state = RSP_ST_IDLE;
		end
		if (nxt_state != state_ff && nxt_state != RSP_ST_IDLE) begin
			nxt_cause = nxt_state;
			// user reset follows the pin rather than driving it
			start = drives_pin(nxt_state);
		end
		nxt_proc_rst_b = (nxt_state == RSP_ST_IDLE) ? RSP_RST_OFF : RSP_RST_ON;
		nxt_periph_rst_b = nxt_proc_rst_b;
	end

	assign pif.start = start;
	assign pif.length = ext_reset_length;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= RSP_ST_IDLE;
			cause_ff <= RSP_ST_IDLE;
			proc_rst_b_ff <= RSP_RST_ON;
			periph_rst_b_ff <= RSP_RST_ON;
		end else begin
			state_ff <= nxt_state;
			cause_ff <= nxt_cause;
			proc_rst_b_ff <= nxt_proc_rst_b;
			periph_rst_b_ff <= nxt_periph_rst_b;
		end
	end

	assign proc_rst_b = proc_rst_b_ff;
	assign periph_rst_b = periph_rst_b_ff;
	assign rst_state = state_ff;
	assign rst_cause = cause_ff;

	property p_hold_while_low;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff != RSP_ST_IDLE && ext_reset_pin_n_lvl == RSP_PIN_LOW && !gen_rst_req)
			|=> (proc_rst_b_ff == RSP_RST_ON && state_ff != RSP_ST_IDLE);
	endproperty
	a_hold_while_low: assert property (p_hold_while_low) else $error("reset released with pin low");

	property p_gen_first;
		@(posedge clk_sys) disable iff (!rst_b)
		gen_rst_req |=> (state_ff == RSP_ST_GEN && proc_rst_b_ff == RSP_RST_ON);
	endproperty
	a_gen_first: assert property (p_gen_first) else $error("general reset not taken");

	property p_bkp_over_wdt;
		@(posedge clk_sys) disable iff (!rst_b)
		(bkp_rst_req && !gen_rst_req && state_ff != RSP_ST_GEN) |=> (state_ff == RSP_ST_BKP);
	endproperty
	a_bkp_over_wdt: assert property (p_bkp_over_wdt) else $error("backup reset not taken");

	property p_user_no_wdt;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == RSP_ST_USER && wdt_event) |=> (state_ff != RSP_ST_WDT);
	endproperty
	a_user_no_wdt: assert property (p_user_no_wdt) else $error("watchdog entered from user reset");

	property p_user_no_sw;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == RSP_ST_USER && sw_rst_req) |=> (state_ff != RSP_ST_SW);
	endproperty
	a_user_no_sw: assert property (p_user_no_sw) else $error("software reset entered from user reset");

	property p_sw_to_wdt;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == RSP_ST_SW && wdt_event && !gen_rst_req && !bkp_rst_req)
			|=> (state_ff == RSP_ST_WDT && ext_reset_pin_n_oe);
	endproperty
	a_sw_to_wdt: assert property (p_sw_to_wdt) else $error("watchdog did not preempt software reset");

	property p_sw_ignores_pin;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == RSP_ST_SW && ext_reset_pin_n_lvl == RSP_PIN_LOW
			&& !gen_rst_req && !bkp_rst_req && !wdt_event) |=> (state_ff == RSP_ST_SW);
	endproperty
	a_sw_ignores_pin: assert property (p_sw_ignores_pin) else $error("pin disturbed software reset");

	property p_wdt_proc_held;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == RSP_ST_WDT) |-> (proc_rst_b_ff == RSP_RST_ON && cause_ff == RSP_ST_WDT);
	endproperty
	a_wdt_proc_held: assert property (p_wdt_proc_held) else $error("processor free in watchdog reset");

	property p_wdt_no_user;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == RSP_ST_WDT && ext_reset_pin_n_lvl == RSP_PIN_LOW) |=> (state_ff != RSP_ST_USER);
	endproperty
	a_wdt_no_user: assert property (p_wdt_no_user) else $error("user reset entered from watchdog");

	property p_drive_on_entry;
		@(posedge clk_sys) disable iff (!rst_b)
		(start) |=> (ext_reset_pin_n_oe && !proc_rst_b_ff);
	endproperty
	a_drive_on_entry: assert property (p_drive_on_entry) else $error("pin not driven on reset entry");

	property p_sw_over_user;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == RSP_ST_IDLE && sw_rst_req && !gen_rst_req && !bkp_rst_req && !wdt_event)
			|=> (state_ff == RSP_ST_SW && cause_ff == RSP_ST_SW);
	endproperty
	a_sw_over_user: assert property (p_sw_over_user) else $error("software reset lost to pin");

	property p_user_follows_pin;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == RSP_ST_IDLE && ext_reset_pin_n_lvl == RSP_PIN_LOW && !ext_reset_pin_n_oe
			&& !gen_rst_req && !bkp_rst_req && !wdt_event && !sw_rst_req)
			|=> (state_ff == RSP_ST_USER && !ext_reset_pin_n_oe);
	endproperty
	a_user_follows_pin: assert property (p_user_follows_pin) else $error("user reset not taken from pin");

	property p_wdt_refused;
		@(posedge clk_sys) disable iff (!rst_b)
		((state_ff == RSP_ST_GEN || state_ff == RSP_ST_BKP) && wdt_event && !gen_rst_req && !bkp_rst_req)
			|=> (state_ff != RSP_ST_WDT);
	endproperty
	a_wdt_refused: assert property (p_wdt_refused) else $error("watchdog overrode a higher reset");

	// release and state come from one next value, so they never disagree
	property p_release_only_idle;
		@(posedge clk_sys) disable iff (!rst_b)
		(proc_rst_b_ff == RSP_RST_OFF) |-> (state_ff == RSP_ST_IDLE && periph_rst_b_ff == RSP_RST_OFF);
	endproperty
	a_release_only_idle: assert property (p_release_only_idle) else $error("reset released outside idle");

	property p_drive_only_low;
		@(posedge clk_sys) disable iff (!rst_b)
		ext_reset_pin_n_oe |-> (ext_reset_pin_n_val == RSP_PIN_LOW && drives_pin(state_ff));
	endproperty
	a_drive_only_low: assert property (p_drive_only_low) else $error("pin driven in a wrong state");

	property p_cause_follows;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff != RSP_ST_IDLE) |-> (cause_ff == state_ff);
	endproperty
	a_cause_follows: assert property (p_cause_follows) else $error("cause does not match state");
endmodule

// *** design/rsp_pkg.sv ***
/*
  rsp_pkg: shared constants and types for the reset state manager.
  Assumes a single slow clock domain for every user of the package.
*/
package rsp_pkg;
	localparam int RSP_LEN_W = 4;
	localparam logic [RSP_LEN_W-1:0] RSP_LEN_RST = 4'h0;
	localparam logic [RSP_LEN_W-1:0] RSP_LEN_MIN = 4'h1;
	localparam logic [RSP_LEN_W-1:0] RSP_CNT_ONE = 4'h1;
	localparam logic RSP_PIN_LOW = 1'b0;
	localparam logic RSP_PIN_HIGH = 1'b1;
	localparam logic RSP_RST_ON = 1'b0;
	localparam logic RSP_RST_OFF = 1'b1;

	typedef enum logic [2:0] {
		RSP_ST_IDLE,
		RSP_ST_GEN,
		RSP_ST_BKP,
		RSP_ST_WDT,
		RSP_ST_SW,
		RSP_ST_USER
	} rsp_state_t;

	// pin drive lasts the programmed count, never less than one cycle
	function automatic logic [RSP_LEN_W-1:0] rsp_eff_len(input logic [RSP_LEN_W-1:0] len);
		rsp_eff_len = (len < RSP_LEN_MIN) ? RSP_LEN_MIN : len;
	endfunction
endpackage

// *** design/rsp_pin_if.sv ***
/*
  rsp_pin_if: carrier between the reset state manager and its pin driver.
  Assumes both ends run on the same slow clock.
*/
`timescale 1ns/1ps
interface rsp_pin_if;
	import rsp_pkg::*;
	logic start;
	logic [RSP_LEN_W-1:0] length;
	logic done;
	logic driving;

	modport mgr (output start, output length, input done, input driving);
	modport drv (input start, input length, output done, output driving);
endinterface

// *** design/rsp_pin_drv.sv ***
/*
  rsp_pin_drv: drives the open-drain external reset pin low for a
  programmed number of slow clock cycles and reports completion.
  Assumes the pin input is synchronous to clk_sys.
*/
`timescale 1ns/1ps
module rsp_pin_drv
	import rsp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// pin level seen from outside
	input wire logic pin_lvl,
	// to the state manager
	rsp_pin_if.drv pif,
	// pin drive
	output logic pin_val,
	output logic pin_oe
);
	logic drive_ff;
	logic nxt_drive;
	logic [RSP_LEN_W-1:0] cnt_ff;
	logic [RSP_LEN_W-1:0] nxt_cnt;
	logic pin_o_ff;

	always_comb begin
		nxt_drive = drive_ff;
		nxt_cnt = cnt_ff;
		if (pif.start) begin
			nxt_drive = 1'b1;
			nxt_cnt = RSP_LEN_RST;
		end else if (drive_ff) begin
			nxt_cnt = cnt_ff + RSP_CNT_ONE;
			if (nxt_cnt >= rsp_eff_len(pif.length)) begin
				nxt_drive = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			drive_ff <= 1'b0;
			cnt_ff <= RSP_LEN_RST;
			pin_o_ff <= RSP_PIN_LOW;
		end else begin
			drive_ff <= nxt_drive;
			cnt_ff <= nxt_cnt;
			pin_o_ff <= RSP_PIN_LOW;
		end
	end

	// done only once the line has really risen, so an outside pull stretches it
	assign pif.done = !drive_ff && (pin_lvl == RSP_PIN_HIGH) && !pif.start;
	assign pif.driving = drive_ff;
	assign pin_val = pin_o_ff;
	assign pin_oe = drive_ff;

	property p_min_low;
		@(posedge clk_sys) disable iff (!rst_b)
		$fell(drive_ff) |-> (cnt_ff >= rsp_eff_len($past(pif.length)));
	endproperty
	a_min_low: assert property (p_min_low) else $error("pin released early");

	property p_cnt_restart;
		@(posedge clk_sys) disable iff (!rst_b)
		pif.start |=> (drive_ff && cnt_ff == RSP_LEN_RST);
	endproperty
	a_cnt_restart: assert property (p_cnt_restart) else $error("count not restarted");
endmodule

// *** bench/rsp_board_line.sv ***
/*
  rsp_board_line: board side of the external reset wire, with pull-up.
  Assumes the device drives only low (open drain) and a board button may hold it low.
*/
`timescale 1ns/1ps
module rsp_board_line (
	// device drive
	input wire logic pin_val,
	input wire logic pin_oe,
	// board button
	input wire logic hold_low,
	// resolved wire
	output logic wire_lvl
);
	// pull-up wins when nobody pulls low
	assign wire_lvl = ((pin_oe && !pin_val) || hold_low) ? 1'b0 : 1'b1;
endmodule

// *** bench/tb_reset_state_priority.sv ***
/*
  tb_reset_state_priority: self-checking bench for rsp_reset_mgr.
  Assumes the board line model resolves the open-drain reset wire.
*/
`timescale 1ns/1ps
module tb_reset_state_priority;
	import rsp_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic gen, bkp, wdt, sw, hold, pin_lvl, pin_o, pin_oe, proc_b, periph_b;
	logic [3:0] len;
	logic [31:0] seed = 32'h46EBCC11;
	rsp_state_t st, cause;
	int failures = 0;
	int cmp_count = 0;
	always #5 clk_sys = ~clk_sys;
	rsp_board_line board (.pin_val(pin_o), .pin_oe(pin_oe), .hold_low(hold), .wire_lvl(pin_lvl));
	rsp_reset_mgr dut (.clk_sys(clk_sys), .rst_b(rst_b), .gen_rst_req(gen), .bkp_rst_req(bkp),
		.wdt_event(wdt), .sw_rst_req(sw), .ext_reset_length(len), .ext_reset_pin_n_lvl(pin_lvl),
		.ext_reset_pin_n_val(pin_o), .ext_reset_pin_n_oe(pin_oe), .proc_rst_b(proc_b),
		.periph_rst_b(periph_b), .rst_state(st), .rst_cause(cause));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// zero length still drives one cycle
	function automatic int eff(input logic [3:0] l);
		return (l == 4'h0) ? 1 : int'(l);
	endfunction
	task automatic give_verdict();
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// one-cycle request, returns when the answer is visible
	task automatic req(input logic [3:0] v);
		{gen, bkp, wdt, sw} = v;
		@(negedge clk_sys);
		{gen, bkp, wdt, sw} = 4'h0;
	endtask
	task automatic cnt_drv(input int exp);
		int n;
		n = 0;
		chk(pin_oe === 1'b1 && pin_o === 1'b0, "pin not pulled low");
		while (pin_oe === 1'b1 && n < 40) begin
			n++;
			@(negedge clk_sys);
		end
		chk(n == exp, "pin drive length");
		if (n >= 40) begin
			give_verdict();
		end
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (st !== RSP_ST_IDLE && n < 60) begin
			n++;
			@(negedge clk_sys);
		end
		chk(st === RSP_ST_IDLE, "no return to idle");
		if (st !== RSP_ST_IDLE) begin
			give_verdict();
		end
		@(negedge clk_sys);
		chk(proc_b === 1'b1 && periph_b === 1'b1, "resets not released");
	endtask
	initial begin
		{gen, bkp, wdt, sw, hold} = 5'h00;
		len = 4'h2;
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_b = 1'b1;
		repeat (2) @(negedge clk_sys);
		// software resets over random lengths, zero and one first
		for (int i = 0; i < 8; i++) begin
			len = (i < 2) ? 4'(i) : 4'(rnd());
			req(4'h1);
			chk(st === RSP_ST_SW && proc_b === 1'b0, "sw reset not taken");
			cnt_drv(eff(len));
			wait_idle();
		end
		// concurrent sources resolve by priority
		req(4'hF);
		chk(st === RSP_ST_GEN && cause === RSP_ST_GEN, "gen priority");
		// a watchdog event while in general reset is refused
		wdt = 1'b1;
		@(negedge clk_sys);
		chk(st === RSP_ST_GEN, "wdt taken over gen");
		wdt = 1'b0;
		wait_idle();
		req(4'h7);
		chk(st === RSP_ST_BKP && cause === RSP_ST_BKP, "bkp priority");
		wait_idle();
		req(4'h3);
		chk(st === RSP_ST_WDT && cause === RSP_ST_WDT, "wdt priority");
		wait_idle();
		// watchdog preempts software reset, count restarts
		len = 4'h5;
		req(4'h1);
		repeat (2) @(negedge clk_sys);
		req(4'h2);
		chk(st === RSP_ST_WDT, "wdt over sw");
		hold = 1'b1;
		sw = 1'b1;
		cnt_drv(5);
		repeat (3) @(negedge clk_sys);
		chk(st === RSP_ST_WDT && proc_b === 1'b0, "wdt left while pin low");
		hold = 1'b0;
		sw = 1'b0;
		wait_idle();
		// board holds the pin during a software reset; software outranks the pin
		len = 4'h2;
		hold = 1'b1;
		req(4'h1);
		chk(st === RSP_ST_SW && cause === RSP_ST_SW, "sw lost to pin");
		cnt_drv(2);
		repeat (4) @(negedge clk_sys);
		chk(st === RSP_ST_SW && periph_b === 1'b0, "pin low not ignored in sw");
		hold = 1'b0;
		wait_idle();
		// user reset blocks watchdog and software requests
		hold = 1'b1;
		@(negedge clk_sys);
		chk(st === RSP_ST_USER && pin_oe === 1'b0 && cause === RSP_ST_USER, "user reset");
		{wdt, sw} = 2'b11;
		repeat (3) @(negedge clk_sys);
		chk(st === RSP_ST_USER && proc_b === 1'b0, "user reset left");
		{wdt, sw} = 2'b00;
		hold = 1'b0;
		wait_idle();
		give_verdict();
	end
	// hang guard
	initial begin
		#500000;
		failures++;
		give_verdict();
	end
endmodule
